// ===== rtl/pmr_insn_tick.sv
/*
 Instruction-cycle enable divider: one-cycle pulse every CLK_PER_INSN clocks.
 Assumes the single 200 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module pmr_insn_tick (
  // Clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_B_I,
  // Enable out
  output logic      tick_o
);

  logic [1:0] cnt_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      cnt_q  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= (cnt_q == pmr_pkg::INSN_DIV_LAST) ? 2'h0 : 2'(cnt_q + 2'h1);
      tick_o <= (cnt_q == pmr_pkg::INSN_DIV_LAST);
    end
  end

endmodule // pmr_insn_tick

// ===== rtl/pmr_pkg.sv
/*
 Package for the program memory read block: register offsets, field
 positions, reset values, fetch timing and carrier structs.
 Assumes an 8-bit register port and a 14-bit wide, 13-bit addressed flash.
*/
package pmr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_CONTROL   = 3'h0;
  localparam logic [2:0] OFS_DATA_LOW  = 3'h1;
  localparam logic [2:0] OFS_DATA_HIGH = 3'h2;
  localparam logic [2:0] OFS_ADDR_LOW  = 3'h3;
  localparam logic [2:0] OFS_ADDR_HIGH = 3'h4;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int         STROBE_BIT     = 0;
  localparam logic [7:0] CONTROL_FIXED  = 8'h80;
  localparam int         ADDR_W         = 13;
  localparam int         WORD_W         = 14;
  localparam int         ADDR_HIGH_W    = 5;
  localparam int         DATA_HIGH_W    = 6;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // ---------------------------------------------------------------
  // Fetch timing: two instruction cycles
  // ---------------------------------------------------------------
  localparam int         FETCH_INSNS    = 2;
  localparam int         CLK_PER_INSN   = 4;
  localparam int         FETCH_CYCLES   = FETCH_INSNS * CLK_PER_INSN;
  localparam logic [1:0] INSN_DIV_LAST  = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } pmr_bus_req_t;

  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } pmr_flash_req_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_LOAD  = 3'b100
  } pmr_state_t;

endpackage

// ===== rtl/pmr_program_memory_read.sv
/*
 Top of the program memory read path: register port, fetch sequencer,
 flash request and result capture.
 Assumes flash returns the word with a valid pulse within the fetch window,
 and that software follows the strobe with two idle instructions.
*/
`timescale 1ns/1ps
module pmr_program_memory_read (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Register port
  input  wire logic [2:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // Code protection state
  input  wire logic        CODE_PROTECT_I,
  // Flash array
  output logic             FLASH_REQ_O,
  output logic [12:0]      FLASH_ADDR_O,
  input  wire logic        FLASH_VALID_I,
  input  wire logic [13:0] FLASH_WORD_I,
  // Status
  output logic             BUSY_O
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pmr_pkg::pmr_bus_req_t   bus;
  pmr_pkg::pmr_flash_req_t flash_d;
  pmr_pkg::pmr_state_t     state_q;
  pmr_pkg::pmr_state_t     state_d;
  logic                    tick;
  logic                    strobe_q;
  logic [4:0]              addr_high_q;
  logic [7:0]              addr_low_q;
  logic [5:0]              data_high_q;
  logic [7:0]              data_low_q;
  logic [13:0]             word_q;
  logic                    word_ok_q;
  logic [1:0]              insn_cnt_q;
  logic                    start;
  logic                    done;
  logic [7:0]              rdata_d;

  assign bus = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};

  pmr_insn_tick u_tick (
    .CLK_I   (CLK_I),
    .RST_B_I (RST_B_I),
    .tick_o  (tick)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  assign start = (state_q == pmr_pkg::ST_IDLE) && bus.wr &&
                 (bus.addr == pmr_pkg::OFS_CONTROL) &&
                 bus.wdata[pmr_pkg::STROBE_BIT];
  assign done  = (state_q == pmr_pkg::ST_LOAD);

  always_comb begin
    state_d = state_q;
    case (state_q)
      pmr_pkg::ST_IDLE: begin
        if (start) begin
          state_d = pmr_pkg::ST_FETCH;
        end
      end
      pmr_pkg::ST_FETCH: begin
        if (tick && insn_cnt_q == 2'(pmr_pkg::FETCH_INSNS - 1)) begin
          state_d = pmr_pkg::ST_LOAD;
        end
      end
      pmr_pkg::ST_LOAD: begin
        state_d = pmr_pkg::ST_IDLE;
      end
      default: begin
        state_d = pmr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q <= pmr_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      insn_cnt_q <= 2'h0;
    end else if (start) begin
      insn_cnt_q <= 2'h0;
    end else if (state_q == pmr_pkg::ST_FETCH && tick) begin
      insn_cnt_q <= 2'(insn_cnt_q + 2'h1);
    end
  end

  // Strobe: set by software only, cleared by hardware at completion
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      strobe_q <= 1'b0;
    end else if (start) begin
      strobe_q <= 1'b1;
    end else if (done) begin
      strobe_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Address registers
  // ---------------------------------------------------------------
  // Writes during a fetch are dropped so the fetched address stays put
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      addr_high_q <= 5'h00;
    end else if (bus.wr && state_q == pmr_pkg::ST_IDLE &&
                 bus.addr == pmr_pkg::OFS_ADDR_HIGH) begin
      addr_high_q <= bus.wdata[pmr_pkg::ADDR_HIGH_W-1:0];
    end
  end

  // No reset: contents unknown after reset
  always_ff @(posedge CLK_I) begin
    if (bus.wr && state_q == pmr_pkg::ST_IDLE &&
        bus.addr == pmr_pkg::OFS_ADDR_LOW) begin
      addr_low_q <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Flash request
  // ---------------------------------------------------------------
  assign flash_d = '{req: start, addr: {addr_high_q, addr_low_q}};

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      FLASH_REQ_O  <= 1'b0;
      FLASH_ADDR_O <= 13'h0000;
    end else begin
      FLASH_REQ_O  <= flash_d.req;
      if (flash_d.req) begin
        FLASH_ADDR_O <= flash_d.addr;
      end
    end
  end

  // Capture the returned word; code protection is not consulted
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      word_q    <= 14'h0000;
      word_ok_q <= 1'b0;
    end else if (start) begin
      word_ok_q <= 1'b0;
    end else if (state_q == pmr_pkg::ST_FETCH && FLASH_VALID_I) begin
      word_q    <= FLASH_WORD_I;
      word_ok_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Data registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      data_high_q <= 6'h00;
      data_low_q  <= 8'h00;
    end else if (done && word_ok_q) begin
      data_high_q <= word_q[pmr_pkg::WORD_W-1:8];
      data_low_q  <= word_q[7:0];
    end else if (bus.wr && state_q == pmr_pkg::ST_IDLE) begin
      if (bus.addr == pmr_pkg::OFS_DATA_HIGH) begin
        data_high_q <= bus.wdata[pmr_pkg::DATA_HIGH_W-1:0];
      end else if (bus.addr == pmr_pkg::OFS_DATA_LOW) begin
        data_low_q <= bus.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = pmr_pkg::RESET_BYTE;
    if (bus.addr == pmr_pkg::OFS_CONTROL) begin
      rdata_d = pmr_pkg::CONTROL_FIXED | {7'h00, strobe_q};
    end else if (bus.addr == pmr_pkg::OFS_DATA_LOW) begin
      rdata_d = data_low_q;
    end else if (bus.addr == pmr_pkg::OFS_DATA_HIGH) begin
      rdata_d = {2'h0, data_high_q};
    end else if (bus.addr == pmr_pkg::OFS_ADDR_LOW) begin
      rdata_d = addr_low_q;
    end else if (bus.addr == pmr_pkg::OFS_ADDR_HIGH) begin
      rdata_d = {3'h0, addr_high_q};
    end
  end

  // Bus reads during a fetch return zero: that instruction is lost
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 8'h00;
    end else if (bus.rd && state_q == pmr_pkg::ST_IDLE) begin
      RDATA_O <= rdata_d;
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= (state_d != pmr_pkg::ST_IDLE);
    end
  end

endmodule // pmr_program_memory_read

// ===== tb/pmr_chk.sv
/* Port checker for the program memory read block.
   Assumes a clean synchronous reset before traffic. */
`timescale 1ns/1ps
module pmr_chk (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  // Register port
  input wire logic [2:0]  ADDR_I,
  input wire logic [7:0]  WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [7:0]  RDATA_O,
  // Flash side
  input wire logic        CODE_PROTECT_I,
  input wire logic        FLASH_REQ_O,
  input wire logic [12:0] FLASH_ADDR_O,
  input wire logic        FLASH_VALID_I,
  input wire logic [13:0] FLASH_WORD_I,
  input wire logic        BUSY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic go;
  logic rdok;
  assign go   = WR_I && ADDR_I == 3'h0 && !BUSY_O;
  assign rdok = RD_I && !BUSY_O;
  AST_START: assert property (go && WDATA_I[0] |=> FLASH_REQ_O)
    else $error("no fetch");
  AST_ZERO: assert property (go && !WDATA_I[0] |=> !FLASH_REQ_O && !BUSY_O)
    else $error("zero strobe fetched");
  AST_SPAN: assert property (FLASH_REQ_O |-> BUSY_O[*6] ##[1:4] !BUSY_O)
    else $error("fetch length");
  AST_ADDR: assert property (FLASH_REQ_O |=> $stable(FLASH_ADDR_O)[*7])
    else $error("address moved");
  AST_BUSYRD: assert property (RD_I && BUSY_O |=> RDATA_O == 8'h00)
    else $error("busy read");
  AST_CTRL: assert property (rdok && ADDR_I == 3'h0 |=> RDATA_O[7:1] == 7'h40)
    else $error("control bits");
  AST_DHI: assert property (rdok && ADDR_I == 3'h2 |=> RDATA_O[7:6] == 2'h0)
    else $error("data high bits");
  AST_AHI: assert property (rdok && ADDR_I == 3'h4 |=> RDATA_O[7:5] == 3'h0)
    else $error("address high bits");
endmodule // pmr_chk
bind pmr_program_memory_read pmr_chk pmr_chk_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .CODE_PROTECT_I(CODE_PROTECT_I), .FLASH_REQ_O(FLASH_REQ_O), .FLASH_ADDR_O(FLASH_ADDR_O),
  .FLASH_VALID_I(FLASH_VALID_I), .FLASH_WORD_I(FLASH_WORD_I), .BUSY_O(BUSY_O));

// ===== tb/pmr_flash_model.sv
/* Flash array model: answers a request with a one-cycle valid pulse.
   Assumes requests are spaced by whole fetches. */
`timescale 1ns/1ps
module pmr_flash_model (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // Request side
  input wire logic        req_i,
  input wire logic [12:0] addr_i,
  input wire logic        slow_i,
  // Answer side
  output logic            valid_o,
  output logic [13:0]     word_o
);
  logic [2:0]  cnt_q;
  logic        pend_q;
  logic [13:0] w_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      {pend_q, valid_o, cnt_q, w_q} <= '0;
    end else begin
      valid_o <= 1'b0;
      if (req_i) begin
        pend_q <= 1'b1;
        cnt_q  <= slow_i ? 3'h1 : 3'h0;
        w_q    <= {1'b0, addr_i} ^ 14'h2C93;
      end else if (pend_q && cnt_q == 3'h0) begin
        pend_q  <= 1'b0;
        valid_o <= 1'b1;
      end else if (pend_q) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
  // Word lines show garbage outside the pulse
  assign word_o = valid_o ? w_q : ~w_q;
endmodule // pmr_flash_model

// ===== tb/tb.sv
/* Self-checking bench for the program memory read block.
   Assumes the flash model and the bound checker. */
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic        cp;
    logic        slow;
    logic [12:0] a;
    logic [13:0] w;
  } pmr_row_t;
  logic clk, rst_b, wr, rd, cp, slow, freq, fvalid, busy;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [12:0] faddr;
  logic [13:0] fword;
  int fails, n_tests;
  pmr_row_t r;
  pmr_row_t rows [4] = '{'{1'b0, 1'b0, 13'h0000, 14'h2C93},
    '{1'b1, 1'b1, 13'h1FFF, 14'h336C}, '{1'b0, 1'b1, 13'h0A5A, 14'h26C9},
    '{1'b1, 1'b0, 13'h15A5, 14'h3936}};
  pmr_program_memory_read pmr_program_memory_read_i (.CLK_I(clk), .RST_B_I(rst_b),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CODE_PROTECT_I(cp), .FLASH_REQ_O(freq), .FLASH_ADDR_O(faddr),
    .FLASH_VALID_I(fvalid), .FLASH_WORD_I(fword), .BUSY_O(busy));
  pmr_flash_model pmr_flash_model_i (.clk_i(clk), .rst_b_i(rst_b), .req_i(freq),
    .addr_i(faddr), .slow_i(slow), .valid_o(fvalid), .word_o(fword));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----
  // Bus and checking tasks
  // ----
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task wait_idle;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      #1 if (busy === 1'b0) return;
    end
    chk(8'hFF, 8'h00);
    wrap_up();
  endtask
  initial begin
    {wr, rd, cp, slow, addr, wdata, rst_b, fails, n_tests} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      {cp, slow} <= {r.cp, r.slow};
      wr_reg(3'h3, r.a[7:0]);
      wr_reg(3'h4, {3'h7, r.a[12:8]});
      wr_reg(3'h0, 8'h81);
      wait_idle();
      rd_reg(3'h1, r.w[7:0]);
      rd_reg(3'h2, {2'h0, r.w[13:8]});
      rd_reg(3'h3, r.a[7:0]);
      rd_reg(3'h4, {3'h0, r.a[12:8]});
      rd_reg(3'h0, 8'h80);
      $display("row %0d done", i);
    end
    wr_reg(3'h0, 8'h81);
    wr_reg(3'h3, 8'h33);
    rd_reg(3'h1, 8'h00);
    wait_idle();
    rd_reg(3'h3, r.a[7:0]);
    wr_reg(3'h0, 8'h80);
    rd_reg(3'h1, r.w[7:0]);
    rd_reg(3'h7, 8'h00);
    $display("busy and strobe test done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(3'h0, 8'h80);
    rd_reg(3'h2, 8'h00);
    rd_reg(3'h4, 8'h00);
    $display("reset test done");
    wrap_up();
  end
endmodule // tb
